// ==== bca_pkg.sv ====
/*
 * Shared constants for the bipolar cell alert threshold block: register
 * indices, field layout, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus and 14-bit bipolar result codes.
 */
`default_nettype none

package bca_pkg;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int LEVEL_W   = 14;
	localparam int FIELD_LSB = 2;
	localparam int FIELD_MSB = 15;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int IDX_LSB   = 2;
	localparam int IDX_W     = 6;

	// ----------------------------------------------------------------
	// Register indices; the byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_OV_CLEAR = 6'h24;
	localparam logic [IDX_W-1:0] IDX_OV_SET   = 6'h25;
	localparam logic [IDX_W-1:0] IDX_UV_CLEAR = 6'h26;
	localparam logic [IDX_W-1:0] IDX_UV_SET   = 6'h27;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h30;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h31;
	localparam logic [IDX_W-1:0] IDX_ALERTS   = 6'h32;

	// ----------------------------------------------------------------
	// Reset values of the threshold fields
	// ----------------------------------------------------------------
	localparam logic [LEVEL_W-1:0] OV_CLEAR_RST = 14'h3fff;
	localparam logic [LEVEL_W-1:0] OV_SET_RST   = 14'h3fff;
	localparam logic [LEVEL_W-1:0] UV_CLEAR_RST = 14'h0000;
	localparam logic [LEVEL_W-1:0] UV_SET_RST   = 14'h0000;

	// ----------------------------------------------------------------
	// Event bits in status and mask
	// ----------------------------------------------------------------
	localparam int EVT_W  = 2;
	localparam int EVT_OV = 0;
	localparam int EVT_UV = 1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ==== bca_axil_slave.sv ====
/*
 * AXI4-Lite slave front end. Takes write address and data in either order,
 * issues one write strobe to the register file, and answers reads from a
 * combinational read port of the register file.
 * Assumes the register file decodes within the same cycle.
 */
`timescale 1ns/1ns
`default_nettype none

module bca_axil_slave #(
	parameter int AW = bca_pkg::ADDR_W,
	parameter int DW = bca_pkg::DATA_W
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic [AW-1:0] awaddr_i,
	input  wire logic          awvalid_i,
	output logic               awready_o,
	input  wire logic [DW-1:0] wdata_i,
	input  wire logic [DW/8-1:0] wstrb_i,
	input  wire logic          wvalid_i,
	output logic               wready_o,
	output logic [1:0]         bresp_o,
	output logic               bvalid_o,
	input  wire logic          bready_i,
	input  wire logic [AW-1:0] araddr_i,
	input  wire logic          arvalid_i,
	output logic               arready_o,
	output logic [DW-1:0]      rdata_o,
	output logic [1:0]         rresp_o,
	output logic               rvalid_o,
	input  wire logic          rready_i,
	output logic               wr_en_o,
	output logic [AW-1:0]      wr_addr_o,
	output logic [DW-1:0]      wr_data_o,
	output logic [DW/8-1:0]    wr_strb_o,
	input  wire logic          wr_hit_i,
	output logic [AW-1:0]      rd_addr_o,
	input  wire logic [DW-1:0] rd_data_i,
	input  wire logic          rd_hit_i
);

	if (DW != 32) begin : g_dw_check
		$error("bca_axil_slave supports 32-bit data only");
	end

	logic            aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [AW-1:0]   awaddr_q, awaddr_d;
	logic [DW-1:0]   wdata_q, wdata_d;
	logic [DW/8-1:0] wstrb_q, wstrb_d;
	logic            bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]      bresp_q, bresp_d, rresp_q, rresp_d;
	logic [DW-1:0]   rdata_q, rdata_d;
	logic            aw_hs, w_hs, ar_hs;

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	assign awready_o = !aw_full_q && !bvalid_q;
	assign wready_o  = !w_full_q && !bvalid_q;
	assign aw_hs     = awvalid_i && awready_o;
	assign w_hs      = wvalid_i && wready_o;
	assign wr_addr_o = aw_full_q ? awaddr_q : awaddr_i;
	assign wr_data_o = w_full_q ? wdata_q : wdata_i;
	assign wr_strb_o = w_full_q ? wstrb_q : wstrb_i;
	assign wr_en_o   = (aw_full_q || aw_hs) && (w_full_q || w_hs);

	always_comb begin
		aw_full_d = aw_full_q;
		w_full_d  = w_full_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		if (aw_hs) begin
			aw_full_d = 1'b1;
			awaddr_d  = awaddr_i;
		end
		if (w_hs) begin
			w_full_d = 1'b1;
			wdata_d  = wdata_i;
			wstrb_d  = wstrb_i;
		end
		if (wr_en_o) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_hit_i ? bca_pkg::RESP_OKAY : bca_pkg::RESP_SLVERR;
		end else if (bvalid_q && bready_i) begin
			bvalid_d = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	assign arready_o = !rvalid_q;
	assign ar_hs     = arvalid_i && arready_o;
	assign rd_addr_o = araddr_i;

	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (ar_hs) begin
			rvalid_d = 1'b1;
			rdata_d  = rd_hit_i ? rd_data_i : '0;
			rresp_d  = rd_hit_i ? bca_pkg::RESP_OKAY : bca_pkg::RESP_SLVERR;
		end else if (rvalid_q && rready_i) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= bca_pkg::RESP_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= bca_pkg::RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	assign bvalid_o = bvalid_q;
	assign bresp_o  = bresp_q;
	assign rvalid_o = rvalid_q;
	assign rdata_o  = rdata_q;
	assign rresp_o  = rresp_q;

endmodule

`default_nettype wire

// ==== bca_hyst_cmp.sv ====
/*
 * One hysteresis alert: sets when a result passes the set level, clears when
 * it returns to the clear level, holds otherwise. LOW_SIDE mirrors the codes so
 * that the same logic serves an undervoltage alert.
 * Assumes result codes order from 0 (lowest) to all ones (highest).
 */
`timescale 1ns/1ns
`default_nettype none

module bca_hyst_cmp #(
	parameter int W        = bca_pkg::LEVEL_W,
	parameter bit LOW_SIDE = 1'b0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         sample_i,
	input  wire logic [W-1:0] value_i,
	input  wire logic [W-1:0] set_level_i,
	input  wire logic [W-1:0] clear_level_i,
	output logic              alert_o,
	output logic              rise_o
);

	logic [W-1:0] v, s, c;
	logic         alert_q, alert_d, rise_q, rise_d;

	// Mirroring turns "below set" into "above set" for the low side.
	assign v = LOW_SIDE ? ~value_i : value_i;
	assign s = LOW_SIDE ? ~set_level_i : set_level_i;
	assign c = LOW_SIDE ? ~clear_level_i : clear_level_i;

	always_comb begin
		alert_d = alert_q;
		if (sample_i) begin
			// Strictly beyond the set level asserts, so the extreme code disables.
			if (v > s) begin
				alert_d = 1'b1;
			end else if (v <= c) begin
				alert_d = 1'b0;
			end
		end
		rise_d = alert_d && !alert_q;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			alert_q <= 1'b0;
			rise_q  <= 1'b0;
		end else begin
			alert_q <= alert_d;
			rise_q  <= rise_d;
		end
	end

	assign alert_o = alert_q;
	assign rise_o  = rise_q;

endmodule

`default_nettype wire

// ==== bca_top.sv ====
/*
 * Bipolar cell alert thresholds: four threshold registers on AXI4-Lite, the
 * hysteresis compare for overvoltage and undervoltage, and an interrupt from
 * sticky alert-rise events.
 * Assumes results arrive on the same clock with a one-cycle valid strobe.
 */
// Notes on behaviour
// - Overvoltage clear level register, index 0x24, field 15:2, resets 0x3fff.
// - Overvoltage alert drops when a bipolar result is at or below clear level.
// - Overvoltage set level register, index 0x25, resets 0x3fff.
// - Overvoltage alert rises when a bipolar result exceeds the 14-bit set level.
// - Set level 0x3fff disables overvoltage checking since nothing exceeds it.
// - Threshold fields use the same bipolar code as the measured results.
// - Undervoltage clear level register, index 0x26, field 15:2, resets 0x0000.
// - Undervoltage alert drops when a bipolar result is at or above clear level.
// - Undervoltage alert rises below set level; set level 0x0000 disables it.
`timescale 1ns/1ns
`default_nettype none

module bca_top (
	input  wire logic                            CLK_I,
	input  wire logic                            RST_I,
	input  wire logic [bca_pkg::ADDR_W-1:0]      S_AXI_AWADDR_I,
	input  wire logic                            S_AXI_AWVALID_I,
	output logic                                 S_AXI_AWREADY_O,
	input  wire logic [bca_pkg::DATA_W-1:0]      S_AXI_WDATA_I,
	input  wire logic [bca_pkg::DATA_W/8-1:0]    S_AXI_WSTRB_I,
	input  wire logic                            S_AXI_WVALID_I,
	output logic                                 S_AXI_WREADY_O,
	output logic [1:0]                           S_AXI_BRESP_O,
	output logic                                 S_AXI_BVALID_O,
	input  wire logic                            S_AXI_BREADY_I,
	input  wire logic [bca_pkg::ADDR_W-1:0]      S_AXI_ARADDR_I,
	input  wire logic                            S_AXI_ARVALID_I,
	output logic                                 S_AXI_ARREADY_O,
	output logic [bca_pkg::DATA_W-1:0]           S_AXI_RDATA_O,
	output logic [1:0]                           S_AXI_RRESP_O,
	output logic                                 S_AXI_RVALID_O,
	input  wire logic                            S_AXI_RREADY_I,
	input  wire logic                            MEAS_VALID_I,
	input  wire logic                            MEAS_BIPOLAR_I,
	input  wire logic [bca_pkg::LEVEL_W-1:0]     MEAS_CODE_I,
	output logic                                 CELL_OVERVOLTAGE_ALERT_O,
	output logic                                 CELL_UNDERVOLTAGE_ALERT_O,
	output logic                                 IRQ_O
);

	localparam int LW = bca_pkg::LEVEL_W;
	localparam int DW = bca_pkg::DATA_W;
	localparam int AW = bca_pkg::ADDR_W;
	localparam int EW = bca_pkg::EVT_W;

	logic          wr_en, wr_hit, rd_hit;
	logic [AW-1:0] wr_addr, rd_addr;
	logic [DW-1:0] wr_data, rd_data;
	logic [DW/8-1:0] wr_strb;

	logic [LW-1:0] ov_clear_q, ov_clear_d, ov_set_q, ov_set_d;
	logic [LW-1:0] uv_clear_q, uv_clear_d, uv_set_q, uv_set_d;
	logic [EW-1:0] stat_q, stat_d, mask_q, mask_d, evt;
	logic          ov_alert, uv_alert, sample;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [bca_pkg::IDX_W-1:0] reg_index(input logic [AW-1:0] a);
		reg_index = a[bca_pkg::IDX_LSB +: bca_pkg::IDX_W];
	endfunction

	function automatic logic is_mapped(input logic [AW-1:0] a);
		unique case (reg_index(a))
			bca_pkg::IDX_OV_CLEAR, bca_pkg::IDX_OV_SET,
			bca_pkg::IDX_UV_CLEAR, bca_pkg::IDX_UV_SET,
			bca_pkg::IDX_IRQ_STAT, bca_pkg::IDX_IRQ_MASK,
			bca_pkg::IDX_ALERTS: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// Merges a write into a threshold field; only lanes 0 and 1 carry it.
	function automatic logic [LW-1:0] merge_level(input logic [LW-1:0] old,
		input logic [DW-1:0] d, input logic [DW/8-1:0] strb);
		logic [15:0] w;
		w = {old, 2'h0};
		if (strb[0]) begin
			w[7:0] = d[7:0];
		end
		if (strb[1]) begin
			w[15:8] = d[15:8];
		end
		merge_level = w[bca_pkg::FIELD_MSB:bca_pkg::FIELD_LSB];
	endfunction

	// ----------------------------------------------------------------
	// Bus front end
	// ----------------------------------------------------------------
	bca_axil_slave #(
		.AW(AW),
		.DW(DW)
	) u_bus (
		.clk_i    (CLK_I),
		.rst_i    (RST_I),
		.awaddr_i (S_AXI_AWADDR_I),
		.awvalid_i(S_AXI_AWVALID_I),
		.awready_o(S_AXI_AWREADY_O),
		.wdata_i  (S_AXI_WDATA_I),
		.wstrb_i  (S_AXI_WSTRB_I),
		.wvalid_i (S_AXI_WVALID_I),
		.wready_o (S_AXI_WREADY_O),
		.bresp_o  (S_AXI_BRESP_O),
		.bvalid_o (S_AXI_BVALID_O),
		.bready_i (S_AXI_BREADY_I),
		.araddr_i (S_AXI_ARADDR_I),
		.arvalid_i(S_AXI_ARVALID_I),
		.arready_o(S_AXI_ARREADY_O),
		.rdata_o  (S_AXI_RDATA_O),
		.rresp_o  (S_AXI_RRESP_O),
		.rvalid_o (S_AXI_RVALID_O),
		.rready_i (S_AXI_RREADY_I),
		.wr_en_o  (wr_en),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wr_strb_o(wr_strb),
		.wr_hit_i (wr_hit),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data),
		.rd_hit_i (rd_hit)
	);

	assign wr_hit = is_mapped(wr_addr);
	assign rd_hit = is_mapped(rd_addr);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always_comb begin
		ov_clear_d = ov_clear_q;
		ov_set_d   = ov_set_q;
		uv_clear_d = uv_clear_q;
		uv_set_d   = uv_set_q;
		mask_d     = mask_q;
		stat_d     = stat_q;
		if (wr_en) begin
			unique case (reg_index(wr_addr))
				bca_pkg::IDX_OV_CLEAR: ov_clear_d = merge_level(ov_clear_q, wr_data, wr_strb);
				bca_pkg::IDX_OV_SET:   ov_set_d   = merge_level(ov_set_q, wr_data, wr_strb);
				bca_pkg::IDX_UV_CLEAR: uv_clear_d = merge_level(uv_clear_q, wr_data, wr_strb);
				bca_pkg::IDX_UV_SET:   uv_set_d   = merge_level(uv_set_q, wr_data, wr_strb);
				bca_pkg::IDX_IRQ_MASK: begin
					if (wr_strb[0]) begin
						mask_d = wr_data[EW-1:0];
					end
				end
				bca_pkg::IDX_IRQ_STAT: begin
					if (wr_strb[0]) begin
						stat_d = stat_q & ~wr_data[EW-1:0];
					end
				end
				default: ;
			endcase
		end
		// A rise in the clearing cycle is kept: set wins over the clear.
		stat_d = stat_d | evt;
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ov_clear_q <= bca_pkg::OV_CLEAR_RST;
			ov_set_q   <= bca_pkg::OV_SET_RST;
			uv_clear_q <= bca_pkg::UV_CLEAR_RST;
			uv_set_q   <= bca_pkg::UV_SET_RST;
			mask_q     <= '0;
			stat_q     <= '0;
		end else begin
			ov_clear_q <= ov_clear_d;
			ov_set_q   <= ov_set_d;
			uv_clear_q <= uv_clear_d;
			uv_set_q   <= uv_set_d;
			mask_q     <= mask_d;
			stat_q     <= stat_d;
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = '0;
		unique case (reg_index(rd_addr))
			bca_pkg::IDX_OV_CLEAR: rd_data[bca_pkg::FIELD_MSB:bca_pkg::FIELD_LSB] = ov_clear_q;
			bca_pkg::IDX_OV_SET:   rd_data[bca_pkg::FIELD_MSB:bca_pkg::FIELD_LSB] = ov_set_q;
			bca_pkg::IDX_UV_CLEAR: rd_data[bca_pkg::FIELD_MSB:bca_pkg::FIELD_LSB] = uv_clear_q;
			bca_pkg::IDX_UV_SET:   rd_data[bca_pkg::FIELD_MSB:bca_pkg::FIELD_LSB] = uv_set_q;
			bca_pkg::IDX_IRQ_STAT: rd_data[EW-1:0] = stat_q;
			bca_pkg::IDX_IRQ_MASK: rd_data[EW-1:0] = mask_q;
			bca_pkg::IDX_ALERTS: begin
				rd_data[bca_pkg::EVT_OV] = ov_alert;
				rd_data[bca_pkg::EVT_UV] = uv_alert;
			end
			default: ;
		endcase
	end

	// ----------------------------------------------------------------
	// Alert compare
	// ----------------------------------------------------------------
	// Unipolar results belong to other thresholds and leave these alerts alone.
	assign sample = MEAS_VALID_I && MEAS_BIPOLAR_I;

	bca_hyst_cmp #(
		.W       (LW),
		.LOW_SIDE(1'b0)
	) u_ov (
		.clk_i        (CLK_I),
		.rst_i        (RST_I),
		.sample_i     (sample),
		.value_i      (MEAS_CODE_I),
		.set_level_i  (ov_set_q),
		.clear_level_i(ov_clear_q),
		.alert_o      (ov_alert),
		.rise_o       (evt[bca_pkg::EVT_OV])
	);

	bca_hyst_cmp #(
		.W       (LW),
		.LOW_SIDE(1'b1)
	) u_uv (
		.clk_i        (CLK_I),
		.rst_i        (RST_I),
		.sample_i     (sample),
		.value_i      (MEAS_CODE_I),
		.set_level_i  (uv_set_q),
		.clear_level_i(uv_clear_q),
		.alert_o      (uv_alert),
		.rise_o       (evt[bca_pkg::EVT_UV])
	);

	assign CELL_OVERVOLTAGE_ALERT_O  = ov_alert;
	assign CELL_UNDERVOLTAGE_ALERT_O = uv_alert;
	assign IRQ_O                     = |(stat_q & mask_q);

endmodule

`default_nettype wire

// ==== bca_chk.sv ====
/* Port checker for bca_top: bus answers and alert hysteresis.
   Assumes it is bound to bca_top, whose ports it watches. */
`timescale 1ns/1ns
`default_nettype none
module bca_chk (
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic        S_AXI_AWVALID_I,
	input wire logic        S_AXI_AWREADY_O,
	input wire logic        S_AXI_WVALID_I,
	input wire logic        S_AXI_WREADY_O,
	input wire logic [1:0]  S_AXI_BRESP_O,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_BREADY_I,
	input wire logic [7:0]  S_AXI_ARADDR_I,
	input wire logic        S_AXI_ARVALID_I,
	input wire logic        S_AXI_ARREADY_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic        S_AXI_RVALID_O,
	input wire logic        S_AXI_RREADY_I,
	input wire logic        MEAS_VALID_I,
	input wire logic        MEAS_BIPOLAR_I,
	input wire logic [13:0] MEAS_CODE_I,
	input wire logic        CELL_OVERVOLTAGE_ALERT_O,
	input wire logic        CELL_UNDERVOLTAGE_ALERT_O
);
	default clocking dc @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// Only threshold registers have spare low bits; status, mask and alerts use them.
	logic rd_thr_q;
	always_ff @(posedge CLK_I) begin
		if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			rd_thr_q <= (S_AXI_ARADDR_I[7:2] >= bca_pkg::IDX_OV_CLEAR)
				&& (S_AXI_ARADDR_I[7:2] <= bca_pkg::IDX_UV_SET);
		end
	end
	// ------------------------
	// Sequences
	// ------------------------
	sequence s_samp;
		MEAS_VALID_I && MEAS_BIPOLAR_I;
	endsequence
	sequence s_wr;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	// ------------------------
	// Assertions
	// ------------------------
	a_ov_hold: assert property (
		!(MEAS_VALID_I && MEAS_BIPOLAR_I) |=> $stable(CELL_OVERVOLTAGE_ALERT_O))
		else $error("ov alert moved without a sample");
	a_uv_hold: assert property (
		!(MEAS_VALID_I && MEAS_BIPOLAR_I) |=> $stable(CELL_UNDERVOLTAGE_ALERT_O))
		else $error("uv alert moved without a sample");
	a_ov_floor_clear: assert property (
		s_samp ##0 (MEAS_CODE_I == 14'h0000) |=> !CELL_OVERVOLTAGE_ALERT_O)
		else $error("ov alert kept at lowest code");
	a_uv_top_clear: assert property (
		s_samp ##0 (MEAS_CODE_I == 14'h3fff) |=> !CELL_UNDERVOLTAGE_ALERT_O)
		else $error("uv alert kept at highest code");
	a_wr_answer: assert property (s_wr |=> S_AXI_BVALID_O)
		else $error("write not answered");
	a_rd_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
		else $error("read not answered");
	a_b_stands: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
		|=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("write response dropped");
	a_r_stands: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
		|=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read response dropped");
	a_spare_zero: assert property (
		S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == 16'h0000
		&& (!rd_thr_q || S_AXI_RDATA_O[1:0] == 2'h0))
		else $error("unused read bits not zero");
endmodule
bind bca_top bca_chk i_chk (.CLK_I(CLK_I), .RST_I(RST_I),
	.S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
	.S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
	.S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
	.S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
	.S_AXI_ARVALID_I(S_AXI_ARVALID_I),
	.S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
	.S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
	.MEAS_VALID_I(MEAS_VALID_I), .MEAS_BIPOLAR_I(MEAS_BIPOLAR_I), .MEAS_CODE_I(MEAS_CODE_I),
	.CELL_OVERVOLTAGE_ALERT_O(CELL_OVERVOLTAGE_ALERT_O),
	.CELL_UNDERVOLTAGE_ALERT_O(CELL_UNDERVOLTAGE_ALERT_O));
`default_nettype wire

// ==== bca_top_tb.sv ====
/* Self-checking bench for bca_top: registers, alerts and interrupt.
   Assumes the bca_pkg register map and a single 50 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
module bca_top_tb;
	logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, mv, mb, ov, uv, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d, e;
	logic [3:0]  ws;
	logic [1:0]  bresp, rresp, r;
	logic [13:0] mc;
	int          bad_count, tests_run, seed, m_ov, m_uv, m_st, ovc, ovs, uvc, uvs;
	logic [31:0] rv [4] = '{32'h0000fffc, 32'h0000fffc, 32'h0, 32'h0};
	logic [13:0] dc [8] = '{14'h3000, 14'h3001, 14'h2801, 14'h2800,
		14'h1000, 14'h0fff, 14'h17ff, 14'h1800};

	bca_top i_dut (.CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .MEAS_VALID_I(mv), .MEAS_BIPOLAR_I(mb), .MEAS_CODE_I(mc),
		.CELL_OVERVOLTAGE_ALERT_O(ov), .CELL_UNDERVOLTAGE_ALERT_O(uv), .IRQ_O(irq));

	// ------------------------
	// Tasks
	// ------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic pa, pw, ta, tw;
		pa = 1;
		pw = 1;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (pa || pw) begin
			@(negedge clk);
			ta = awready;
			tw = wready;
			@(posedge clk);
			if (ta) begin
				awvalid <= 1'b0;
				pa = 0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				pw = 0;
			end
		end
		do begin
			@(negedge clk);
		end while (!bvalid);
		@(posedge clk);
		bready <= 1'b1;
		@(negedge clk);
		rs = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge clk);
		end while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do begin
			@(negedge clk);
		end while (!rvalid);
		@(posedge clk);
		rready <= 1'b1;
		@(negedge clk);
		v = rdata;
		rs = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	task automatic samp(input logic b, input logic [13:0] c);
		int po, pu;
		po = m_ov;
		pu = m_uv;
		@(posedge clk);
		mv <= 1'b1;
		mb <= b;
		mc <= c;
		@(posedge clk);
		mv <= 1'b0;
		if (b) begin
			if (c > ovs) m_ov = 1; else if (c <= ovc) m_ov = 0;
			if (c < uvs) m_uv = 1; else if (c >= uvc) m_uv = 0;
		end
		if (m_ov > po) m_st |= 1;
		if (m_uv > pu) m_st |= 2;
		@(negedge clk);
		check({30'h0, uv, ov}, 32'(m_uv * 2 + m_ov));
	endtask
	task automatic irq_is(input int e);
		@(negedge clk);
		check({31'h0, irq}, 32'(e));
	endtask

	// ------------------------
	// Sequence of tests
	// ------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// The span allows the whole sequence several times over.
	initial begin
		#1000000;
		bad_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		finish_test();
	end
	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready, mv, mb} = 8'hff ^ 8'h7f;
		{awaddr, araddr, wdata, mc} = '0;
		ws = 4'hf;
		{bad_count, tests_run, m_ov, m_uv, m_st, ovc, uvc, uvs} = '0;
		ovs = 32'h3fff;
		ovc = 32'h3fff;
		seed = 98;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(8'h90 + 8'(i * 4), d, r);
			check(d, rv[i]);
		end
		samp(1'b1, 14'h3fff);
		samp(1'b1, 14'h0000);
		$display("reset and disable test done");
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			wr(8'h90 + 8'(i * 4), d, r);
			check({30'h0, r}, {30'h0, bca_pkg::RESP_OKAY});
			rd(8'h90 + 8'(i * 4), e, r);
			check(e, d & 32'h0000fffc);
		end
		// A write on lane 1 alone must keep the lane 0 part of the field.
		ws <= 4'h2;
		wr(8'h9c, ~d, r);
		ws <= 4'hf;
		rd(8'h9c, e, r);
		check(e, {16'h0, ~d[15:8], d[7:2], 2'h0});
		wr(8'ha0, 32'h5, r);
		check({30'h0, r}, {30'h0, bca_pkg::RESP_SLVERR});
		rd(8'ha0, d, r);
		check({d[29:0], r}, {30'h0, bca_pkg::RESP_SLVERR});
		$display("register test done");
		ovc = 32'h2800;
		ovs = 32'h3000;
		uvc = 32'h1800;
		uvs = 32'h1000;
		wr(8'h90, 32'(ovc * 4 + 3), r);
		wr(8'h94, 32'(ovs * 4 + 3), r);
		wr(8'h98, 32'(uvc * 4 + 3), r);
		wr(8'h9c, 32'(uvs * 4 + 3), r);
		for (int i = 0; i < 8; i++) samp(1'b1, dc[i]);
		for (int i = 0; i < 200; i++) samp(1'($random(seed)), 14'($random(seed)));
		rd(8'hc8, d, r);
		check(d, 32'(m_uv * 2 + m_ov));
		$display("alert test done");
		rd(8'hc0, d, r);
		check(d, 32'(m_st));
		irq_is(0);
		wr(8'hc4, 32'h1, r);
		irq_is(m_st & 1);
		wr(8'hc0, 32'h1, r);
		m_st &= 2;
		rd(8'hc0, d, r);
		check(d, 32'(m_st));
		irq_is(0);
		wr(8'hc4, 32'h3, r);
		irq_is(m_st != 0);
		rd(8'hc4, d, r);
		check(d, 32'h3);
		wr(8'hc0, 32'h3, r);
		irq_is(0);
		$display("interrupt test done");
		finish_test();
	end
endmodule
`default_nettype wire
